// *** core/pmon_pkg.sv ***
// Package: register map, field layouts and helpers of the perfmon register bank
package pmon_pkg;
  // ************************************************************
  // Register map, byte offsets from the perfmon table base
  // ************************************************************
  localparam logic [15:0] OFS_CAP    = 16'h0000;
  localparam logic [15:0] OFS_RST    = 16'h0010;
  localparam logic [15:0] OFS_FRZ    = 16'h0020;
  localparam logic [15:0] OFS_OVF    = 16'h0030;
  localparam logic [15:0] OFS_CFG    = 16'h0100;
  localparam logic [15:0] OFS_VAL    = 16'h0200;
  localparam logic [15:0] OFS_FLT    = 16'h0400;
  localparam logic [15:0] STRIDE_REG = 16'h0008;
  localparam logic [15:0] STRIDE_FLT = 16'h0040;
  localparam int          REG_BYTES  = 8;

  // ************************************************************
  // Capability fields
  // ************************************************************
  localparam int CAP_IRQ_BIT  = 55;
  localparam int CAP_FRZ_BIT  = 54;
  localparam int CAP_WWE_BIT  = 53;
  localparam int CAP_PCC_BIT  = 52;
  localparam int CAP_FLT_LSB  = 36;
  localparam int CAP_CATM_LSB = 20;
  localparam int CAP_NCAT_LSB = 16;
  localparam int CAP_CW_LSB   = 8;
  localparam int CAP_NCNT_LSB = 0;

  // ************************************************************
  // Counter configuration fields and control bits
  // ************************************************************
  localparam int          CFG_EN_BIT   = 0;
  localparam int          CFG_IRQ_BIT  = 1;
  localparam int          CFG_FOVF_BIT = 2;
  localparam logic [63:0] CFG_WMASK    = 64'h0000_0fff_ffff_ff07;
  localparam logic [63:0] CFG_RESET    = 64'h0000_0000_0000_0000;
  localparam int          RST_CNT_BIT  = 0;
  localparam int          RST_CFG_BIT  = 1;
  localparam int          FRZ_BIT      = 0;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [63:0] wdata;
    logic [7:0]  be;
  } pmon_req_t;

  function automatic logic [63:0] pmon_merge(input logic [63:0] old_v, input logic [63:0] new_v,
                                             input logic [7:0] be);
    logic [63:0] r;
    r = old_v;
    for (int i = 0; i < REG_BYTES; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic int pmon_popcount(input logic [7:0] m);
    int n;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      n = n + int'(m[i]);
    end
    return n;
  endfunction
endpackage

// *** core/pmon_counter_slice.sv ***
// One performance counter: configuration, filters and value with write protection
`timescale 1ns/1ns
`default_nettype none
module pmon_counter_slice import pmon_pkg::*; #(
  parameter int CNT_W   = 32,
  parameter int NUM_FLT = 4,
  parameter bit WWE     = 1'b0,
  parameter bit FRZ_SUP = 1'b1
) (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        wr_cfg,
  input  wire logic                        wr_val,
  input  wire logic [NUM_FLT-1:0]          wr_flt,
  input  wire logic [63:0]                 wdata,
  input  wire logic [7:0]                  be,
  input  wire logic                        rst_cnt,
  input  wire logic                        rst_cfg,
  input  wire logic                        frozen,
  input  wire logic                        event_in,
  output logic      [63:0]                 cfg,
  output logic      [CNT_W-1:0]            value,
  output logic      [NUM_FLT-1:0][63:0]    flt,
  output logic                             ovf
);
  logic             enabled;
  logic [63:0]      wmask;
  logic [63:0]      next_cfg;
  logic [CNT_W-1:0] next_val;
  logic             counting;

  assign enabled  = cfg[CFG_EN_BIT];
  // Freeze-on-overflow bit reads zero when freeze is absent
  assign wmask    = FRZ_SUP ? CFG_WMASK : (CFG_WMASK & ~(64'h1 << CFG_FOVF_BIT));
  assign next_cfg = pmon_merge(cfg, wdata & wmask, be);
  assign next_val = CNT_W'(pmon_merge(64'(value), 64'(wdata), be));
  assign counting = enabled && !frozen && event_in;
  assign ovf      = counting && (value == {CNT_W{1'b1}});

  // ************************************************************
  // Configuration
  // ************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= CFG_RESET;
    end else if (rst_cfg) begin
      cfg <= CFG_RESET;
    end else if (wr_cfg && enabled) begin
      if (be[0]) begin
        cfg[CFG_EN_BIT] <= wdata[CFG_EN_BIT];
      end
    end else if (wr_cfg) begin
      cfg <= next_cfg;
    end
  end

  // ************************************************************
  // Filters, one register per supported filter
  // ************************************************************
  for (genvar f = 0; f < NUM_FLT; f++) begin : g_flt
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        flt[f] <= '0;
      end else if (rst_cfg) begin
        flt[f] <= '0;
      end else if (wr_flt[f] && !enabled) begin
        flt[f] <= pmon_merge(flt[f], wdata, be);
      end
    end
  end

  // ************************************************************
  // Counter value
  // ************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      value <= '0;
    end else if (rst_cnt) begin
      value <= '0;
    end else if (wr_val && (!enabled || WWE)) begin
      value <= next_val;
    end else if (counting) begin
      value <= value + CNT_W'(1);
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_locked_cfg_write;
    wr_cfg && enabled && !rst_cfg;
  endsequence

  a_cfg_fields_held: assert property (@(posedge clk) disable iff (!reset_n)
    s_locked_cfg_write |=> cfg[63:1] == $past(cfg[63:1]))
    else $error("config field changed while counter enabled");

  a_flt_held: assert property (@(posedge clk) disable iff (!reset_n)
    (|wr_flt) && enabled && !rst_cfg |=> flt == $past(flt))
    else $error("filter changed while counter enabled");

  a_val_rejected: assert property (@(posedge clk) disable iff (!reset_n)
    (!WWE && wr_val && enabled && !rst_cnt && !counting) |=> value == $past(value))
    else $error("counter value written while enabled");

  a_val_accepted: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_val && !enabled && !rst_cnt) |=> value == $past(next_val))
    else $error("counter value write lost while disabled");
endmodule
`default_nettype wire

// *** core/pmon_regbank.sv ***
// Perfmon register bank: capability register, control registers and counters
// Behaviour
// - While counter enabled, config writes change only its enable bit.
// - Filter registers of an enabled counter ignore writes.
// - Without write-while-enabled, value writes rejected while enabled; always accepted when disabled.
// - Reset control, overflow flags and freeze stay writable at all times; reset control reads as zero.
// - Capability bit 55 reports overflow interrupt; per-counter config bit gates it.
// - Capability bit 54 reports freeze support; zero means freeze controls absent.
// - Capability bit 53 is one only if enabled counters accept value writes.
// - Capability bit 52 reports per-counter capability registers; here absent, zero.
// - Bits 43:36 hold supported filter mask, zero if none.
// - Each counter has one filter register per set mask bit.
// - Bits 35:20 hold the event category mask.
// - Bits 19:16 hold the number of event categories.
// - Bits 15:8 hold the counter width.
// - Bits 5:0 hold the counter count; zero means no counting.
// - Capability register is one 64-bit read-only word at table start.
`timescale 1ns/1ns
`default_nettype none
module pmon_regbank import pmon_pkg::*; #(
  parameter int         NUM_CNT  = 4,
  parameter int         CNT_W    = 32,
  parameter logic [7:0] FLT_MASK = 8'h0f,
  parameter logic [15:0] CAT_MASK = 16'h001f,
  parameter logic [3:0] NUM_CAT  = 4'h5,
  parameter bit         IRQ_SUP  = 1'b1,
  parameter bit         FRZ_SUP  = 1'b1,
  parameter bit         WWE      = 1'b0
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                req_valid,
  input  wire pmon_req_t           req,
  output logic                     ack,
  output logic      [63:0]         rdata,
  input  wire logic [NUM_CNT-1:0]  event_in,
  output logic      [NUM_CNT-1:0]  ovf_irq
);
  localparam int NUM_FLT = pmon_popcount(FLT_MASK);
  localparam int NF      = (NUM_FLT > 0) ? NUM_FLT : 1;

  // ************************************************************
  // Capability word
  // ************************************************************
  localparam logic [63:0] CAP_VALUE =
    (64'(IRQ_SUP) << CAP_IRQ_BIT) |
    (64'(FRZ_SUP) << CAP_FRZ_BIT) |
    (64'(WWE) << CAP_WWE_BIT) |
    (64'h0 << CAP_PCC_BIT) |
    (64'(FLT_MASK) << CAP_FLT_LSB) |
    (64'(CAT_MASK) << CAP_CATM_LSB) |
    (64'(NUM_CAT) << CAP_NCAT_LSB) |
    (64'(8'(CNT_W)) << CAP_CW_LSB) |
    (64'(6'(NUM_CNT)) << CAP_NCNT_LSB);

  logic                          wr;
  logic                          rd;
  logic [NUM_CNT-1:0]            wr_cfg;
  logic [NUM_CNT-1:0]            wr_val;
  logic [NUM_CNT-1:0][NF-1:0]    wr_flt;
  logic [NUM_CNT-1:0][63:0]      cfg;
  logic [NUM_CNT-1:0][CNT_W-1:0] value;
  logic [NUM_CNT-1:0][NF-1:0][63:0] flt;
  logic [NUM_CNT-1:0]            ovf;
  logic [NUM_CNT-1:0]            ovf_flags;
  logic                          frozen;
  logic                          rst_cnt;
  logic                          rst_cfg;
  logic [63:0]                   next_rdata;

  assign wr = req_valid && req.we;
  assign rd = req_valid && !req.we;
  // Reset control is a self-clearing command, acting the cycle it is written
  assign rst_cnt = wr && (req.addr == OFS_RST) && req.be[0] && req.wdata[RST_CNT_BIT];
  assign rst_cfg = wr && (req.addr == OFS_RST) && req.be[0] && req.wdata[RST_CFG_BIT];

  // ************************************************************
  // Counters
  // ************************************************************
  for (genvar n = 0; n < NUM_CNT; n++) begin : g_cnt
    always_comb begin
      wr_cfg[n] = wr && (req.addr == OFS_CFG + 16'(n) * STRIDE_REG);
      wr_val[n] = wr && (req.addr == OFS_VAL + 16'(n) * STRIDE_REG);
      for (int f = 0; f < NF; f++) begin
        wr_flt[n][f] = wr && (NUM_FLT > 0) &&
                       (req.addr == OFS_FLT + 16'(n) * STRIDE_FLT + 16'(f) * STRIDE_REG);
      end
    end

    pmon_counter_slice #(
      .CNT_W   (CNT_W),
      .NUM_FLT (NF),
      .WWE     (WWE),
      .FRZ_SUP (FRZ_SUP)
    ) u_slice (
      .clk      (clk),
      .reset_n  (reset_n),
      .wr_cfg   (wr_cfg[n]),
      .wr_val   (wr_val[n]),
      .wr_flt   (wr_flt[n]),
      .wdata    (req.wdata),
      .be       (req.be),
      .rst_cnt  (rst_cnt),
      .rst_cfg  (rst_cfg),
      .frozen   (frozen),
      .event_in (event_in[n]),
      .cfg      (cfg[n]),
      .value    (value[n]),
      .flt      (flt[n]),
      .ovf      (ovf[n])
    );

    // Interrupt only when supported and enabled per counter
    assign ovf_irq[n] = IRQ_SUP && ovf[n] && cfg[n][CFG_IRQ_BIT];
  end

  // ************************************************************
  // Overflow flags, write one to clear, set wins
  // ************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_flags <= '0;
    end else begin
      for (int n = 0; n < NUM_CNT; n++) begin
        if (ovf[n]) begin
          ovf_flags[n] <= 1'b1;
        end else if (wr && (req.addr == OFS_OVF) && req.be[n/8] && req.wdata[n]) begin
          ovf_flags[n] <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // Freeze control
  // ************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frozen <= 1'b0;
    end else if (!FRZ_SUP) begin
      frozen <= 1'b0;
    end else if (|(ovf & {NUM_CNT{1'b1}} & freeze_on_ovf())) begin
      frozen <= 1'b1;
    end else if (wr && (req.addr == OFS_FRZ) && req.be[0]) begin
      frozen <= req.wdata[FRZ_BIT];
    end
  end

  function automatic logic [NUM_CNT-1:0] freeze_on_ovf();
    logic [NUM_CNT-1:0] m;
    for (int n = 0; n < NUM_CNT; n++) begin
      m[n] = cfg[n][CFG_FOVF_BIT];
    end
    return m;
  endfunction

  // ************************************************************
  // Read path, one cycle to answer
  // ************************************************************
  always_comb begin
    next_rdata = '0;
    if (req.addr == OFS_CAP) begin
      next_rdata = CAP_VALUE;
    end else if (req.addr == OFS_FRZ) begin
      next_rdata = 64'(frozen);
    end else if (req.addr == OFS_OVF) begin
      next_rdata = 64'(ovf_flags);
    end
    for (int n = 0; n < NUM_CNT; n++) begin
      if (req.addr == OFS_CFG + 16'(n) * STRIDE_REG) begin
        next_rdata = cfg[n];
      end
      if (req.addr == OFS_VAL + 16'(n) * STRIDE_REG) begin
        next_rdata = 64'(value[n]);
      end
      for (int f = 0; f < NUM_FLT; f++) begin
        if (req.addr == OFS_FLT + 16'(n) * STRIDE_FLT + 16'(f) * STRIDE_REG) begin
          next_rdata = flt[n][f];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req_valid;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= '0;
    end else if (rd) begin
      rdata <= next_rdata;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_cap_read;
    rd && (req.addr == OFS_CAP);
  endsequence

  sequence s_cap_answer;
    ack && (rdata == CAP_VALUE);
  endsequence

  a_cap_read_value: assert property (@(posedge clk) disable iff (!reset_n)
    s_cap_read |=> s_cap_answer)
    else $error("capability read returned wrong word");

  a_cap_write_ignored: assert property (@(posedge clk) disable iff (!reset_n)
    (wr && req.addr == OFS_CAP) ##[1:8] s_cap_read |=> s_cap_answer)
    else $error("capability register changed by a write");

  a_cap_fields: assert property (@(posedge clk) disable iff (!reset_n)
    s_cap_read |=> rdata[5:0] == 6'(NUM_CNT) && rdata[15:8] == 8'(CNT_W) && rdata[63:56] == 8'h00)
    else $error("capability count or width field wrong");

  a_cap_flags: assert property (@(posedge clk) disable iff (!reset_n)
    s_cap_read |=> rdata[CAP_IRQ_BIT] == IRQ_SUP && rdata[CAP_FRZ_BIT] == FRZ_SUP && rdata[CAP_WWE_BIT] == WWE)
    else $error("capability support flags wrong");

  a_ovf_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
    (|ovf) |=> (ovf_flags & $past(ovf)) == $past(ovf))
    else $error("overflow flag lost");

  a_frz_written: assert property (@(posedge clk) disable iff (!reset_n)
    (FRZ_SUP && wr && req.addr == OFS_FRZ && req.be[0] && !(|(ovf & freeze_on_ovf())))
    |=> frozen == $past(req.wdata[FRZ_BIT]))
    else $error("freeze write not taken");
endmodule
`default_nettype wire

// *** tb/pmon_regbank_tb_top.sv ***
// Self-checking testbench of the perfmon register bank
`timescale 1ns/1ns
`default_nettype none
module pmon_regbank_tb_top import pmon_pkg::*;;
  // ************************************************************
  // Configuration, signals and the device under test
  // ************************************************************
  localparam int          NCNT = 4;
  localparam int          CW   = 32;
  localparam logic [7:0]  FLTM = 8'h0f;
  localparam logic [15:0] CATM = 16'h001f;
  localparam logic [3:0]  NCAT = 4'h5;
  localparam logic [63:0] CAP_EXP = {8'h00, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, FLTM, CATM, NCAT, 8'h20, 2'b00, 6'h04};

  logic                  clk;
  logic                  reset_n;
  logic                  req_valid;
  pmon_req_t             req;
  logic                  ack;
  logic       [63:0]     rdata;
  logic       [NCNT-1:0] ev;
  logic       [NCNT-1:0] ovf_irq;
  logic       [63:0]     rd;
  logic       [63:0]     keep [4];
  int                    n_fail;
  int                    n_checks;
  int                    n_ovf;
  int                    n_stray;

  pmon_regbank #(.NUM_CNT(NCNT), .CNT_W(CW), .FLT_MASK(FLTM), .CAT_MASK(CATM), .NUM_CAT(NCAT),
                 .IRQ_SUP(1'b1), .FRZ_SUP(1'b1), .WWE(1'b0)) uut (
    .clk       (clk),
    .reset_n   (reset_n),
    .req_valid (req_valid),
    .req       (req),
    .ack       (ack),
    .rdata     (rdata),
    .event_in  (ev),
    .ovf_irq   (ovf_irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Interrupt pulses are one cycle wide, so count them at every edge
  // Counters 0 to 2 never wrap, so any pulse there is stray
  always @(posedge clk) begin
    if (!reset_n) begin
      n_ovf   <= 0;
      n_stray <= 0;
    end else begin
      if (ovf_irq[3] === 1'b1) begin
        n_ovf <= n_ovf + 1;
      end
      if (ovf_irq[2:0] !== 3'b000) begin
        n_stray <= n_stray + 1;
      end
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Request held until its taking edge; answer taken when ack is high
  task automatic bus(input logic we, input logic [15:0] addr, input logic [63:0] wd, input logic [7:0] be);
    int i;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{we: we, addr: addr, wdata: wd, be: be};
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    i = 0;
    while (ack !== 1'b1 && i < 8) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (ack !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: no answer", $time);
      tally_and_finish();
    end
    check(64'(i), 64'h0);
    rd = rdata;
  endtask

  task automatic wr(input logic [15:0] addr, input logic [63:0] wd);
    bus(1'b1, addr, wd, 8'hff);
  endtask

  task automatic rdr(input logic [15:0] addr);
    bus(1'b0, addr, 64'h0, 8'h00);
  endtask

  function automatic logic [15:0] cfg_a(input int n);
    return OFS_CFG + STRIDE_REG * 16'(n);
  endfunction

  function automatic logic [15:0] val_a(input int n);
    return OFS_VAL + STRIDE_REG * 16'(n);
  endfunction

  function automatic logic [15:0] flt_a(input int n, input int f);
    return OFS_FLT + STRIDE_FLT * 16'(n) + STRIDE_REG * 16'(f);
  endfunction

  // Events on counter 3 for three cycles across a wrap
  task automatic wrap3(input logic [63:0] cfg_v, output int cnt);
    int base;
    wr(val_a(3), 64'h0000_0000_ffff_fffe);
    wr(cfg_a(3), cfg_v);
    base = n_ovf;
    @(posedge clk);
    ev <= 4'h8;
    repeat (3) @(posedge clk);
    ev <= 4'h0;
    @(posedge clk);
    #1;
    cnt = n_ovf - base;
  endtask

  // One event on counter 0
  task automatic pulse0();
    @(posedge clk);
    ev <= 4'h1;
    @(posedge clk);
    ev <= 4'h0;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_cap();
    rdr(OFS_CAP);
    check(rd, CAP_EXP);
    @(posedge clk);
    #1;
    check({63'h0, ack}, 64'h0);
    wr(OFS_CAP, 64'hffff_ffff_ffff_ffff);
    bus(1'b1, OFS_CAP, 64'h0, 8'h0f);
    rdr(OFS_CAP);
    check(rd, CAP_EXP);
    rdr(16'h0ff8);
    check(rd, 64'h0);
    $display("test_cap done");
  endtask

  task automatic test_cfg();
    wr(cfg_a(0), 64'h0000_0000_0000_0301);
    rdr(cfg_a(0));
    check(rd, 64'h0000_0000_0000_0301 & CFG_WMASK);
    wr(cfg_a(0), 64'h0000_0000_0000_0501);
    rdr(cfg_a(0));
    check(rd, 64'h0000_0000_0000_0301);
    wr(cfg_a(0), 64'h0000_0000_0000_0500);
    rdr(cfg_a(0));
    check(rd, 64'h0000_0000_0000_0300);
    wr(cfg_a(0), 64'h0000_0000_0000_0500);
    rdr(cfg_a(0));
    check(rd, 64'h0000_0000_0000_0500);
    $display("test_cfg done");
  endtask

  task automatic test_flt();
    for (int f = 0; f < 4; f++) begin
      wr(flt_a(1, f), 64'hffff_ffff_ffff_ffff);
      rdr(flt_a(1, f));
      keep[f] = rd;
      check(rd, 64'hffff_ffff_ffff_ffff);
    end
    wr(flt_a(1, 4), 64'hffff_ffff_ffff_ffff);
    rdr(flt_a(1, 4));
    check(rd, 64'h0);
    wr(cfg_a(1), 64'h1);
    for (int f = 0; f < 4; f++) begin
      wr(flt_a(1, f), 64'h0);
      rdr(flt_a(1, f));
      check(rd, keep[f]);
    end
    wr(cfg_a(1), 64'h0);
    wr(flt_a(1, 0), 64'h0);
    rdr(flt_a(1, 0));
    check(rd, 64'h0);
    $display("test_flt done");
  endtask

  task automatic test_val();
    wr(val_a(2), 64'h0000_0000_1234_5678);
    rdr(val_a(2));
    check(rd, 64'h0000_0000_1234_5678);
    wr(cfg_a(2), 64'h1);
    wr(val_a(2), 64'h0000_0000_dead_beef);
    rdr(val_a(2));
    check(rd, 64'h0000_0000_1234_5678);
    wr(cfg_a(2), 64'h0);
    wr(val_a(2), 64'h0000_0000_dead_beef);
    rdr(val_a(2));
    check(rd, 64'h0000_0000_dead_beef);
    $display("test_val done");
  endtask

  task automatic test_ovf();
    int c;
    wrap3(64'h3, c);
    check(64'(c), 64'h1);
    rdr(val_a(3));
    check(rd, 64'h1);
    rdr(OFS_OVF);
    check(rd, 64'h8);
    wr(OFS_OVF, 64'h8);
    rdr(OFS_OVF);
    check(rd, 64'h0);
    wr(cfg_a(3), 64'h0);
    wrap3(64'h1, c);
    check(64'(c), 64'h0);
    check(64'(n_stray), 64'h0);
    wr(cfg_a(3), 64'h0);
    $display("test_ovf done");
  endtask

  task automatic test_ctrl();
    wr(cfg_a(0), 64'h0);
    wr(val_a(0), 64'h0000_0000_0000_0055);
    wr(cfg_a(0), 64'h1);
    wr(OFS_FRZ, 64'h1);
    rdr(OFS_FRZ);
    check(rd, 64'h1);
    pulse0();
    rdr(val_a(0));
    check(rd, 64'h0000_0000_0000_0055);
    wr(OFS_FRZ, 64'h0);
    rdr(OFS_FRZ);
    check(rd, 64'h0);
    pulse0();
    rdr(val_a(0));
    check(rd, 64'h0000_0000_0000_0056);
    wr(OFS_RST, 64'h1);
    rdr(val_a(0));
    check(rd, 64'h0);
    rdr(OFS_RST);
    check(rd, 64'h0);
    wr(OFS_RST, 64'h2);
    rdr(cfg_a(0));
    check(rd, 64'h0);
    $display("test_ctrl done");
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    ev = '0;
    n_fail = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    test_cap();
    test_cfg();
    test_flt();
    test_val();
    test_ovf();
    test_ctrl();
    tally_and_finish();
  end
endmodule
`default_nettype wire
